// ===== hw/this_timer.sv
// Chosen here: the register offsets and the APB interface to the registers.
`include "this_timer_defines.svh"
`default_nettype none
module this_timer
	import this_timer_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_count_clock_pin,
	input wire logic companion_osc_enable,
	input wire logic companion_osc_clock,
	input wire logic special_event_trigger,
	input wire logic [1:0] port_c_direction,
	input wire logic [1:0] port_c_pin_in,
	output logic [1:0] port_c_pin_dir,
	output logic [1:0] port_c_pin_read,
	output logic [1:0] timebase_select,
	output logic overflow_event
);
	third_timer_control_t ctrl_r;
	logic [COUNT_WIDTH-1:0] count_r;
	logic [7:0] high_buf_r;
	logic ovf_flag_r;
	logic [1:0] div_r;
	logic [2:0] pre_r;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_prev_r;
	ext_state_t ext_state_r;
	ext_state_t ext_state_nxt;
	apb_resp_t resp_r;
	apb_resp_t resp_nxt;

	wire setup = psel && !penable;
	wire wr_en = setup && pwrite;
	wire rd_en = setup && !pwrite;
	wire hit_ctrl = paddr == `CTRL_OFFSET;
	wire hit_low = paddr == `COUNT_LOW_OFFSET;
	wire hit_high = paddr == `COUNT_HIGH_OFFSET;
	wire hit_stat = paddr == `STATUS_OFFSET;
	wire hit_any = hit_ctrl || hit_low || hit_high || hit_stat;

	// Source clock: oscillator replaces pin when enabled
	wire ext_raw = companion_osc_enable ? companion_osc_clock : ext_count_clock_pin;
	// Bypass reads the raw level; synchronised path adds two flops
	wire ext_lvl = ctrl_r.ext_clock_sync_bypass ? ext_raw : ext_s2_r;
	wire ext_rise = ext_lvl && !ext_prev_r;
	wire ext_fall = !ext_lvl && ext_prev_r;
	wire int_tick = div_r == 2'(`INSTR_DIV - 1);
	wire src_ext = ctrl_r.count_source_select;
	// Sync bit only matters on the external path
	wire src_tick = src_ext ? (ext_rise && ext_state_r == ext_armed) : int_tick;
	wire [1:0] ps = {ctrl_r.prescale_select_high, ctrl_r.prescale_select_low};
	wire [2:0] pre_mask = ps == 2'b00 ? 3'b000 : ps == 2'b01 ? 3'b001 :
		ps == 2'b10 ? 3'b011 : 3'b111;
	wire pre_done = (pre_r & pre_mask) == pre_mask;
	wire cnt_tick = ctrl_r.counter_run && src_tick && pre_done;
	wire roll = cnt_tick && (&count_r);

	// Byte lanes of the count
	wire [7:0] cnt_lo = count_r[7:0];
	wire [7:0] cnt_hi = count_r[COUNT_WIDTH-1:8];
	// Wide mode: high read from buffer latched at low read
	wire [7:0] rd_high = ctrl_r.wide_access_mode ? high_buf_r : cnt_hi;
	wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_r} :
		hit_low ? {24'h000000, cnt_lo} :
		hit_high ? {24'h000000, rd_high} :
		hit_stat ? {31'h00000000, ovf_flag_r} : 32'h00000000;
	wire stat_clr = wr_en && hit_stat && pwdata[0];

	always_comb begin
		resp_nxt = '0;
		if (rd_en) begin
			resp_nxt.prdata = rd_mux;
		end
		resp_nxt.pready = setup;
		resp_nxt.pslverr = setup && !hit_any;
	end

	always_comb begin
		ext_state_nxt = ext_state_r;
		case (ext_state_r)
			ext_off: begin
				if (src_ext) begin
					ext_state_nxt = ext_wait_fall;
				end
			end
			ext_wait_fall: begin
				if (!src_ext) begin
					ext_state_nxt = ext_off;
				end else if (ext_fall) begin
					ext_state_nxt = ext_armed;
				end
			end
			ext_armed: begin
				if (!src_ext) begin
					ext_state_nxt = ext_off;
				end
			end
			default: begin
				ext_state_nxt = ext_off;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			resp_r <= '0;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_state_r <= ext_off;
		end else begin
			ext_state_r <= ext_state_nxt;
		end
	end

	// Only the second stage feeds the edge logic
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_raw;
			ext_s2_r <= ext_s1_r;
		end
	end

	// Resets low like an idle pin, so no false edge after reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_lvl;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= third_timer_control_t'(`CTRL_RESET);
		end else if (wr_en && hit_ctrl) begin
			ctrl_r <= third_timer_control_t'(pwdata[7:0]);
		end
	end

	// Prescaler restarts on any control or count write
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_r <= 3'h0;
		end else if (wr_en && (hit_ctrl || hit_low || hit_high)) begin
			pre_r <= 3'h0;
		end else if (ctrl_r.counter_run && src_tick) begin
			pre_r <= pre_done ? 3'h0 : pre_r + 3'h1;
		end
	end

	// Trigger beats software writes and counting
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_r <= '0;
		end else if (special_event_trigger) begin
			count_r <= '0;
		end else if (wr_en && hit_low) begin
			// Wide write commits buffered high with the low byte
			if (ctrl_r.wide_access_mode) begin
				count_r <= {high_buf_r, pwdata[7:0]};
			end else begin
				count_r[7:0] <= pwdata[7:0];
			end
		end else if (wr_en && hit_high && !ctrl_r.wide_access_mode) begin
			count_r[COUNT_WIDTH-1:8] <= pwdata[7:0];
		end else if (cnt_tick) begin
			count_r <= count_r + 1'b1;
		end
	end

	// Shared buffer: loaded by low read, or by high write in either mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			high_buf_r <= 8'h00;
		end else if (wr_en && hit_high) begin
			high_buf_r <= pwdata[7:0];
		end else if (rd_en && hit_low) begin
			high_buf_r <= cnt_hi;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ovf_flag_r <= 1'b0;
		end else begin
			ovf_flag_r <= roll || (ovf_flag_r && !stat_clr);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			overflow_event <= 1'b0;
		end else begin
			overflow_event <= roll;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			port_c_pin_dir <= 2'h0;
		end else begin
			port_c_pin_dir <= companion_osc_enable ? 2'h3 : port_c_direction;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			port_c_pin_read <= 2'h0;
		end else begin
			port_c_pin_read <= companion_osc_enable ? 2'h0 : port_c_pin_in;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timebase_select <= 2'h0;
		end else begin
			timebase_select <= {ctrl_r.timebase_select_high, ctrl_r.timebase_select_low};
		end
	end

	assign prdata = resp_r.prdata;
	assign pready = resp_r.pready;
	assign pslverr = resp_r.pslverr;
endmodule : this_timer
`default_nettype wire

// ===== hw/this_timer_defines.svh
`ifndef THIS_TIMER_DEFINES_SVH
`define THIS_TIMER_DEFINES_SVH
`define CTRL_OFFSET 12'h000
`define COUNT_LOW_OFFSET 12'h004
`define COUNT_HIGH_OFFSET 12'h008
`define STATUS_OFFSET 12'h00c
`define CTRL_RESET 8'h00
`define BIT_WIDE 7
`define BIT_TBS_HI 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_TBS_LO 3
`define BIT_SYNC_BYP 2
`define BIT_SRC 1
`define BIT_RUN 0
`define INSTR_DIV 4
`endif

// ===== hw/this_timer_pkg.sv
`default_nettype none
package this_timer_pkg;
	typedef struct packed {
		logic wide_access_mode;
		logic timebase_select_high;
		logic prescale_select_high;
		logic prescale_select_low;
		logic timebase_select_low;
		logic ext_clock_sync_bypass;
		logic count_source_select;
		logic counter_run;
	} third_timer_control_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_resp_t;
	typedef enum logic [2:0] {
		ext_wait_fall = 3'b001,
		ext_armed = 3'b010,
		ext_off = 3'b100
	} ext_state_t;
endpackage : this_timer_pkg
`default_nettype wire

// ===== verification/ext_clk_model.sv
`default_nettype none
module ext_clk_model (
	input wire logic go,
	output var logic clk_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial clk_out = 1'b0;
	// Idles low, so the first edge is a rise that must not count
	always @(posedge go) begin
		repeat (5) begin
			#23 clk_out = 1'b1;
			#23 clk_out = 1'b0;
		end
	end
endmodule : ext_clk_model
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0, go = '0, trig = '0, osc = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, ext, err;
	logic [1:0] tbs, pdir, prd;
	int fails = 0, num_checks = 0, cyc = 0;
	ext_clk_model i_ext (.go, .clk_out(ext));
	this_timer i_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_count_clock_pin(ext), .companion_osc_enable(osc),
		.companion_osc_clock(ext), .special_event_trigger(trig), .port_c_direction(2'h1),
		.port_c_pin_in(2'h2), .port_c_pin_dir(pdir), .port_c_pin_read(prd), .timebase_select(tbs),
		.overflow_event());
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d = '0);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : xfer
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("%0d checks, %0d mismatches", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic zero();
		xfer(1, 12'h004);
		xfer(1, 12'h008);
	endtask : zero
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		xfer(0, 12'h010);
		chk(q, 32'h0);
		chk(err, 1'b1);
		for (int p = 0; p < 4; p++) begin
			zero();
			xfer(1, 12'h000, p << 4 | (p & 1) << 2 | 1);
			repeat (32 << p) @(posedge mclk);
			xfer(1, 12'h000, p << 4);
			repeat (40) @(posedge mclk);
			xfer(0, 12'h004);
			chk(q > 6 && q < 10, 1'b1);
			$display("prescale %0d done", p);
		end
		xfer(1, 12'h008, 32'hff);
		xfer(1, 12'h004, 32'hff);
		xfer(1, 12'h000, 32'h1);
		repeat (12) @(posedge mclk);
		xfer(0, 12'h00c);
		chk(q[0], 1'b1);
		xfer(1, 12'h00c, 32'h1);
		xfer(0, 12'h00c);
		chk(q[0], 1'b0);
		$display("overflow done");
		xfer(1, 12'h000, 32'h88);
		chk(tbs, 2'h1);
		xfer(1, 12'h008, 32'h12);
		xfer(0, 12'h004);
		xfer(0, 12'h008);
		chk(q, 32'h0);
		xfer(1, 12'h008, 32'h12);
		xfer(1, 12'h004, 32'h34);
		xfer(0, 12'h004);
		chk(q, 32'h34);
		xfer(0, 12'h008);
		chk(q, 32'h12);
		xfer(1, 12'h000, 32'hc8);
		chk(tbs, 2'h3);
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
		xfer(0, 12'h004);
		chk(q, 32'h0);
		xfer(0, 12'h008);
		chk(q, 32'h0);
		$display("wide done");
		for (int s = 0; s < 3; s++) begin
			xfer(1, 12'h000);
			zero();
			osc <= s == 2;
			xfer(1, 12'h000, (s & 1) << 2 | 3);
			go <= 1'b1;
			repeat (60) @(posedge mclk);
			go <= 1'b0;
			xfer(0, 12'h004);
			chk(q, 32'h4);
			chk({pdir, prd}, s == 2 ? 4'hc : 4'h6);
		end
		$display("external done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire

// ===== verification/this_timer_chk.sv
`default_nettype none
module this_timer_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic companion_osc_enable,
	input wire logic [1:0] port_c_pin_dir,
	input wire logic [1:0] port_c_pin_read,
	input wire logic [1:0] timebase_select,
	input wire logic overflow_event
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire setup = psel && !penable;
	wire bad = paddr[1:0] != 2'h0 || paddr > 12'h00c;
	sequence ctrl_wr_s;
		setup && pwrite && paddr == 12'h000 ##1 1'b1;
	endsequence
	one_wait_a: assert property (setup |=> pready) else $error("ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pulse");
	bad_addr_a: assert property (setup |=> pslverr == $past(bad)) else $error("err");
	err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("data");
	timebase_a: assert property (ctrl_wr_s |=> timebase_select ==
		{$past(pwdata[6], 2), $past(pwdata[3], 2)}) else $error("timebase");
	osc_dir_a: assert property (companion_osc_enable |=> port_c_pin_dir == 2'h3)
		else $error("dir");
	osc_read_a: assert property (companion_osc_enable |=> port_c_pin_read == 2'h0)
		else $error("read");
	ovf_pulse_a: assert property (overflow_event |=> !overflow_event [*8])
		else $error("overflow");
endmodule : this_timer_chk
bind this_timer this_timer_chk i_chk (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata,
	.pready, .pslverr, .companion_osc_enable, .port_c_pin_dir, .port_c_pin_read,
	.timebase_select, .overflow_event);
`default_nettype wire
